/* File: design/asx_pkg.sv */
package asx_pkg;

    // ------------------------------------------------------------
    // register map (word index on the plain port)
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS = 3'h0;   // serial_status_one
    localparam logic [2:0] ADDR_DATA = 3'h1;     // serial_data_register
    localparam logic [2:0] ADDR_CTRL = 3'h2;     // serial_control_two
    localparam logic [2:0] ADDR_CFG = 3'h3;      // serial_config
    localparam logic [2:0] ADDR_BAUD = 3'h4;     // baud_divisor
    localparam logic [2:0] ADDR_EV_STAT = 3'h5;  // event_status, read only
    localparam logic [2:0] ADDR_EV_CLR = 3'h6;   // event_clear, write only
    localparam logic [2:0] ADDR_EV_EN = 3'h7;    // event_enable

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned ST_TXE = 7;   // tx_buffer_empty_flag
    localparam int unsigned ST_TXC = 6;   // tx_complete_flag
    localparam int unsigned ST_RXF = 5;   // rx_full_flag
    localparam int unsigned ST_IDLE = 4;  // idle line flag
    localparam int unsigned ST_OVR = 3;   // overrun flag
    localparam int unsigned ST_NOISE = 2; // noise_flag
    localparam int unsigned CT_TX_ON = 3; // tx_on
    localparam int unsigned CT_RX_ON = 2; // receiver on
    localparam int unsigned CT_BRK = 0;   // send_break_request
    localparam int unsigned CF_RX8 = 7;   // received ninth bit, read only
    localparam int unsigned CF_TX8 = 6;   // ninth bit to send
    localparam int unsigned CF_NINE = 4;  // data width: nine bits
    localparam int unsigned CF_ILT = 2;   // idle_count_after_stop
    localparam int unsigned CF_INV = 0;   // tx_polarity_invert

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'hc0;
    localparam logic [7:0] FLAGS_MASK = 8'hfc;
    localparam logic [7:0] RX_FLAGS = 8'h3c;
    localparam logic [7:0] BAUD_RESET = 8'h0c;

    // ------------------------------------------------------------
    // bit timing (sixteen sample ticks per bit)
    // ------------------------------------------------------------
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] SAMP_LO_START = 4'h3;  // seven start samples
    localparam logic [3:0] SAMP_LO_DATA = 4'h7;   // three samples per bit
    localparam logic [3:0] SAMP_HI = 4'h9;
    localparam logic [3:0] PH_RESYNC = 4'h8;
    localparam logic [2:0] NSAMP_START = 3'h7;
    localparam logic [2:0] NSAMP_DATA = 3'h3;
    localparam logic [3:0] BITS_8 = 4'ha;
    localparam logic [3:0] BITS_9 = 4'hb;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asx_rx_st_t;

    // plain register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } asx_bus_req_t;

    // divider state
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } asx_div_state_t;

    // whole state of the serial block
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic [7:0] flags;
        logic [7:0] snap;
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [7:0] baud;
        logic [7:0] ev_stat;
        logic [7:0] ev_en;
        logic [7:0] rdata;
        logic txd;
        logic tx_busy;
        logic tx_buf_full;
        logic pre_pend;
        logic brk_pend;
        logic [7:0] tx_buf;
        logic [10:0] tx_sh;
        logic [3:0] tx_cnt;
        logic [3:0] tx_ph;
        asx_rx_st_t rx_st;
        logic [3:0] rx_ph;
        logic [3:0] rx_cnt;
        logic [2:0] rx_ones;
        logic rx_noise;
        logic rx8;
        logic idle_arm;
        logic [9:0] rx_sh;
        logic [7:0] rx_data;
        logic [7:0] idle_cnt;
    } asx_state_t;

endpackage

/* File: design/asx_serial_top.sv */
// Behaviour
// - buffer empty flag: reset, transfer; read-then-write clears
// - complete flag set when idle, buffer empty and no preamble or break queued
// - complete clears: status read, then write/enable/break
// - full flag on receive; read-then-read clears
// - idle flag after one high character time
// - idle counting starts after start or stop bit
// - idle clears by reads; rearmed only by reception
// - overrun drops new character; cleared by reads
// - seven start, three bit samples; noise flag
// - noise clears by status then data read
// - falling edges in first half of a data bit resync bit timing
// - line idles high; invert bit flips output
// - enable queues one idle preamble frame
// - data write loads transmit buffer
// - shifter ten or eleven bits by width
// - buffer moves to shifter on bit tick
// - empty after stop: complete, idle high
module asx_serial_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire asx_pkg::asx_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic rxd,
    output logic txd,
    output logic irq
);

    asx_pkg::asx_state_t q, d;  // whole block state
    logic ovs_tick;             // sixteen per bit time
    logic [7:0] set_f;          // flags raised by hardware
    logic [7:0] clr_f;          // flags cleared by access sequence
    logic rd_st, rd_dat, wr_dat, wr_ctl, wr_clr;
    logic rx_fall;              // synchronised falling edge
    logic tx_bit;               // transmit bit boundary
    logic samp;                 // inside sampling window
    logic bit_val;              // majority of samples
    logic bit_noise;            // samples disagree
    logic idle_ok;              // idle counter may run
    logic tx_cond;              // transmitter fully idle
    logic nine;                 // nine bit data mode
    logic [3:0] nbits;          // bits per character
    logic [2:0] nsamp;          // samples in current bit
    logic [10:0] frame;         // data frame for the shifter

    // ------------------------------------------------------------
    // sample tick divider
    // ------------------------------------------------------------
    asx_tick_div u_div (
        .core_clk(core_clk),
        .rstn(rstn),
        .div(q.baud),
        .tick(ovs_tick)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        set_f = '0;
        clr_f = '0;
        // receive pin synchroniser
        d.rx_s1 = rxd;
        d.rx_s2 = q.rx_s1;
        d.rx_prev = q.rx_s2;
        rx_fall = q.rx_prev & ~q.rx_s2;
        nine = q.cfg[asx_pkg::CF_NINE];
        nbits = nine ? asx_pkg::BITS_9 : asx_pkg::BITS_8;
        // decode of the plain port
        rd_st = bus_req.rd && bus_req.addr == asx_pkg::ADDR_STATUS;
        rd_dat = bus_req.rd && bus_req.addr == asx_pkg::ADDR_DATA;
        wr_dat = bus_req.wr && bus_req.addr == asx_pkg::ADDR_DATA;
        wr_ctl = bus_req.wr && bus_req.addr == asx_pkg::ADDR_CTRL;
        wr_clr = bus_req.wr && bus_req.addr == asx_pkg::ADDR_EV_CLR;

        // read data, valid only in the cycle after the strobe
        d.rdata = '0;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                asx_pkg::ADDR_STATUS: d.rdata = q.flags;
                asx_pkg::ADDR_DATA: d.rdata = q.rx_data;
                asx_pkg::ADDR_CTRL: d.rdata = q.ctrl;
                asx_pkg::ADDR_CFG:
                    d.rdata = {q.rx8, q.cfg[6:0]};
                asx_pkg::ADDR_BAUD: d.rdata = q.baud;
                asx_pkg::ADDR_EV_STAT: d.rdata = q.ev_stat;
                asx_pkg::ADDR_EV_EN: d.rdata = q.ev_en;
                default: d.rdata = '0;  // clear register reads zero
            endcase
        end

        // status read remembers which flags were seen set
        if (rd_st)
            d.snap = q.flags;
        // data read clears receive flags seen set
        if (rd_dat)
        begin
            clr_f = clr_f | (q.snap & asx_pkg::RX_FLAGS);
            d.snap = d.snap & ~asx_pkg::RX_FLAGS;
        end
        // data write clears both transmit flags seen set
        if (wr_dat)
        begin
            clr_f[asx_pkg::ST_TXE] = q.snap[asx_pkg::ST_TXE];
            clr_f[asx_pkg::ST_TXC] = q.snap[asx_pkg::ST_TXC];
            d.snap[asx_pkg::ST_TXE] = 1'b0;
            d.snap[asx_pkg::ST_TXC] = 1'b0;
        end
        // control write: enable edge queues preamble, break bit queues
        if (wr_ctl)
        begin
            d.ctrl = bus_req.wdata;
            if (bus_req.wdata[asx_pkg::CT_TX_ON] &&
                !q.ctrl[asx_pkg::CT_TX_ON])
            begin
                d.pre_pend = 1'b1;
                clr_f[asx_pkg::ST_TXC] = q.snap[asx_pkg::ST_TXC];
                d.snap[asx_pkg::ST_TXC] = 1'b0;
            end
            if (bus_req.wdata[asx_pkg::CT_BRK])
            begin
                d.brk_pend = 1'b1;
                clr_f[asx_pkg::ST_TXC] = q.snap[asx_pkg::ST_TXC];
                d.snap[asx_pkg::ST_TXC] = 1'b0;
            end
        end
        // plain configuration registers
        if (bus_req.wr && bus_req.addr == asx_pkg::ADDR_CFG)
            d.cfg = {1'b0, bus_req.wdata[6:0]};
        if (bus_req.wr && bus_req.addr == asx_pkg::ADDR_BAUD)
            d.baud = bus_req.wdata;
        if (bus_req.wr && bus_req.addr == asx_pkg::ADDR_EV_EN)
            d.ev_en = bus_req.wdata & asx_pkg::FLAGS_MASK;

        // --------------------------------------------------------
        // transmitter
        // --------------------------------------------------------
        if (ovs_tick)
            d.tx_ph = q.tx_ph + 4'h1;
        tx_bit = ovs_tick && q.tx_ph == asx_pkg::OVS_LAST;
        // start low, data lsb first, stop high
        frame = nine ? {1'b1, q.cfg[asx_pkg::CF_TX8], q.tx_buf, 1'b0}
                     : {2'b11, q.tx_buf, 1'b0};
        if (tx_bit)
        begin
            if (q.tx_busy && q.tx_cnt != 4'h1)
            begin
                // shift next bit out, fill with idle level
                d.tx_sh = {1'b1, q.tx_sh[10:1]};
                d.tx_cnt = q.tx_cnt - 4'h1;
            end
            else if (q.ctrl[asx_pkg::CT_TX_ON] && q.pre_pend)
            begin
                // one whole frame at the idle level
                d.tx_sh = '1;
                d.tx_cnt = nbits;
                d.tx_busy = 1'b1;
                d.pre_pend = 1'b0;
            end
            else if (q.ctrl[asx_pkg::CT_TX_ON] && q.brk_pend)
            begin
                // one whole frame held low
                d.tx_sh = '0;
                d.tx_cnt = nbits;
                d.tx_busy = 1'b1;
                d.brk_pend = 1'b0;
            end
            else if (q.ctrl[asx_pkg::CT_TX_ON] && q.tx_buf_full)
            begin
                // buffer into shifter on the bit tick
                d.tx_sh = frame;
                d.tx_cnt = nbits;
                d.tx_busy = 1'b1;
                d.tx_buf_full = 1'b0;
                set_f[asx_pkg::ST_TXE] = 1'b1;
            end
            else
            begin
                // stop bit done, nothing waiting
                d.tx_busy = 1'b0;
            end
        end
        // a write the same cycle lands after the shifter took the old one
        if (wr_dat)
        begin
            d.tx_buf = bus_req.wdata;
            d.tx_buf_full = 1'b1;
        end
        // complete while nothing is sent or waiting
        tx_cond = !d.tx_busy && !d.tx_buf_full && !d.pre_pend &&
                  !d.brk_pend;
        set_f[asx_pkg::ST_TXC] = tx_cond;
        // idle level high, optionally inverted
        d.txd = (d.tx_busy ? d.tx_sh[0] : 1'b1) ^
                d.cfg[asx_pkg::CF_INV];

        // --------------------------------------------------------
        // receiver
        // --------------------------------------------------------
        nsamp = (q.rx_st == asx_pkg::RX_START) ? asx_pkg::NSAMP_START
                                               : asx_pkg::NSAMP_DATA;
        samp = q.rx_ph >= ((q.rx_st == asx_pkg::RX_START) ?
                   asx_pkg::SAMP_LO_START : asx_pkg::SAMP_LO_DATA) &&
               q.rx_ph <= asx_pkg::SAMP_HI;
        bit_val = {q.rx_ones, 1'b0} > {1'b0, nsamp};
        bit_noise = q.rx_ones != 3'h0 && q.rx_ones != nsamp;
        unique case (q.rx_st)
            asx_pkg::RX_IDLE:
            begin
                // wait for a start edge
                if (rx_fall && q.ctrl[asx_pkg::CT_RX_ON])
                begin
                    d.rx_st = asx_pkg::RX_START;
                    d.rx_ph = '0;
                    d.rx_ones = '0;
                end
            end
            asx_pkg::RX_START, asx_pkg::RX_BITS:
            begin
                if (q.rx_st == asx_pkg::RX_BITS && rx_fall &&
                    q.rx_ph < asx_pkg::PH_RESYNC)
                begin
                    // late edge marks the true bit boundary
                    d.rx_ph = '0;
                    d.rx_ones = '0;
                end
                else if (ovs_tick)
                begin
                    d.rx_ph = q.rx_ph + 4'h1;
                    if (samp)
                        d.rx_ones = q.rx_ones + {2'b00, q.rx_s2};
                    if (q.rx_ph == asx_pkg::OVS_LAST)
                    begin
                        d.rx_ones = '0;
                        if (q.rx_st == asx_pkg::RX_START)
                        begin
                            // high majority means a false start
                            d.rx_st = bit_val ? asx_pkg::RX_IDLE
                                              : asx_pkg::RX_BITS;
                            d.rx_cnt = '0;
                            d.rx_noise = bit_noise;
                        end
                        else
                        begin
                            d.rx_sh = {bit_val, q.rx_sh[9:1]};
                            d.rx_cnt = q.rx_cnt + 4'h1;
                            d.rx_noise = q.rx_noise | bit_noise;
                            if (q.rx_cnt == nbits - 4'h2)
                            begin
                                // stop bit sampled, character done
                                d.rx_st = asx_pkg::RX_IDLE;
                                if (q.flags[asx_pkg::ST_RXF])
                                begin
                                    // no room: drop it with its errors
                                    set_f[asx_pkg::ST_OVR] = 1'b1;
                                end
                                else
                                begin
                                    d.rx_data = nine ? d.rx_sh[7:0]
                                                     : d.rx_sh[8:1];
                                    d.rx8 = nine & d.rx_sh[8];
                                    set_f[asx_pkg::ST_RXF] = 1'b1;
                                    set_f[asx_pkg::ST_NOISE] =
                                        d.rx_noise;
                                    d.idle_arm = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
        endcase
        if (!q.ctrl[asx_pkg::CT_RX_ON])
            d.rx_st = asx_pkg::RX_IDLE;

        // idle line: count high ticks, either from start or after stop
        idle_ok = q.rx_s2 && q.ctrl[asx_pkg::CT_RX_ON] &&
                  (q.cfg[asx_pkg::CF_ILT] ? q.rx_st == asx_pkg::RX_IDLE
                       : q.rx_st != asx_pkg::RX_START);
        if (!idle_ok)
            d.idle_cnt = '0;
        else if (ovs_tick && q.idle_cnt != {nbits, 4'h0})
            d.idle_cnt = q.idle_cnt + 8'h01;
        if (q.idle_cnt == {nbits, 4'h0} && q.idle_arm)
        begin
            // one full character time high, once per arming
            set_f[asx_pkg::ST_IDLE] = 1'b1;
            d.idle_arm = 1'b0;
        end

        // --------------------------------------------------------
        // flags and events: a set beats a clear in the same cycle
        // --------------------------------------------------------
        d.flags = (set_f | (q.flags & ~clr_f)) & asx_pkg::FLAGS_MASK;
        d.ev_stat = (set_f & ~q.flags) |
                    (q.ev_stat & ~(wr_clr ? bus_req.wdata : 8'h00));
        d.ev_stat = d.ev_stat & asx_pkg::FLAGS_MASK;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            q <= '0;
            q.flags <= asx_pkg::FLAGS_RESET;
            q.baud <= asx_pkg::BAUD_RESET;
            q.txd <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_rdata = q.rdata;
    assign txd = q.txd;
    assign irq = |(q.ev_stat & q.ev_en);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_txe_seen;
        rd_st && q.flags[asx_pkg::ST_TXE];
    endsequence
    // one cycle with no access between the two steps
    sequence s_bus_quiet;
        !bus_req.rd && !bus_req.wr;
    endsequence
    sequence s_data_wr_no_move;
        wr_dat && !tx_bit;
    endsequence
    // fixed spacing: a move in the gap cannot mask the clear
    property p_txe_clear;
        s_txe_seen ##1 s_bus_quiet ##1 s_data_wr_no_move
            |=> !q.flags[asx_pkg::ST_TXE];
    endproperty
    a_txe_clear: assert property (p_txe_clear)
        else $error("buffer empty flag not cleared");

    property p_tc_set;
        tx_cond |=> q.flags[asx_pkg::ST_TXC];
    endproperty
    a_tc_set: assert property (p_tc_set)
        else $error("complete flag missing while idle");

    property p_tc_break_clear;
        rd_st && q.flags[asx_pkg::ST_TXC] ##1 s_bus_quiet ##1
            (wr_ctl && bus_req.wdata[asx_pkg::CT_BRK])
            |=> !q.flags[asx_pkg::ST_TXC] && q.brk_pend;
    endproperty
    a_tc_break_clear: assert property (p_tc_break_clear)
        else $error("break request did not clear complete flag");

    property p_rxf_clear;
        rd_st && q.flags[asx_pkg::ST_RXF] ##1 s_bus_quiet ##1
            (rd_dat && !set_f[asx_pkg::ST_RXF])
            |=> !q.flags[asx_pkg::ST_RXF];
    endproperty
    a_rxf_clear: assert property (p_rxf_clear)
        else $error("full flag not cleared by read sequence");

    property p_overrun;
        set_f[asx_pkg::ST_OVR] |=> q.flags[asx_pkg::ST_OVR] &&
            $stable(q.rx_data);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun did not keep old character");

    property p_noise_with_full;
        $rose(q.flags[asx_pkg::ST_NOISE]) |->
            $rose(q.flags[asx_pkg::ST_RXF]);
    endproperty
    a_noise_with_full: assert property (p_noise_with_full)
        else $error("noise flag rose apart from full flag");

    property p_idle_once;
        $rose(q.flags[asx_pkg::ST_IDLE]) |-> !q.idle_arm;
    endproperty
    a_idle_once: assert property (p_idle_once)
        else $error("idle detection still armed after flag");

    property p_txd_idle;
        !q.tx_busy && !q.cfg[asx_pkg::CF_INV] && $stable(q.cfg)
            |-> q.txd;
    endproperty
    a_txd_idle: assert property (p_txd_idle)
        else $error("transmit line not high while idle");

    property p_start_bit;
        tx_bit && set_f[asx_pkg::ST_TXE] |=>
            (q.txd == q.cfg[asx_pkg::CF_INV]) && q.tx_cnt == nbits;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("frame did not open with a start bit");

    property p_preamble;
        wr_ctl && bus_req.wdata[asx_pkg::CT_TX_ON] &&
            !q.ctrl[asx_pkg::CT_TX_ON] |=> q.pre_pend;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("enable did not queue a preamble");

endmodule

/* File: design/asx_tick_div.sv */
// sample tick divider: one pulse every div+1 clocks
module asx_tick_div (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] div,
    output logic tick
);

    asx_pkg::asx_div_state_t q, d;  // whole divider state

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt >= div)
        begin
            // wrap, also covers a divisor lowered mid count
            d.cnt = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 8'h01;
        end
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

endmodule

/* File: verif/asx_far_end.sv */
module asx_far_end (
    input wire logic core_clk,
    input wire logic go,
    input wire logic noisy,
    input wire logic [7:0] data_in,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT_CLKS = 16; // divisor 0: sixteen clocks a bit
    logic [9:0] frame; // stop, data, start
    initial line = 1'b1;
    // one frame per go pulse; line rests at mark level between frames
    always @(posedge core_clk)
    begin
        if (go)
        begin
            frame = {1'b1, data_in, 1'b0};
            for (int i = 0; i < 10; i++)
            begin
                // noisy: one clock spike in mid first data bit
                for (int k = 0; k < BIT_CLKS; k++)
                begin
                    line <= (noisy && i == 1 && k == 9) ? ~frame[i]
                                                        : frame[i];
                    @(posedge core_clk);
                end
            end
        end
    end
endmodule

/* File: verif/test_asx_serial_top.sv */
module test_asx_serial_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk;
    logic rstn;
    asx_pkg::asx_bus_req_t req;
    logic [7:0] bus_rdata;
    logic rxd;
    logic txd;
    logic irq;
    logic go;
    logic noisy;
    logic [7:0] far_data;
    logic [7:0] d;
    logic [9:0] fr;
    int n_mismatch;
    int samples_checked;
    int n;
    asx_serial_top dut_u (.core_clk(core_clk), .rstn(rstn), .bus_req(req),
        .bus_rdata(bus_rdata), .rxd(rxd), .txd(txd), .irq(irq));
    asx_far_end far_u (.core_clk(core_clk), .go(go), .noisy(noisy),
        .data_in(far_data), .line(rxd));
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // one-cycle register write
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
        #1;
    endtask
    // read, data taken in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 v = bus_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        rd(a, d);
        chk(d & m, exp);
    endtask
    // far end sends one character, then the line rests
    task automatic send(input logic [7:0] v);
        @(posedge core_clk);
        go <= 1'b1;
        far_data <= v;
        @(posedge core_clk);
        go <= 1'b0;
        cyc(200);
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        rstn = 1'b0;
        req = '0;
        go = 1'b0;
        noisy = 1'b0;
        far_data = 8'h00;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        rchk(asx_pkg::ADDR_STATUS, 8'hff, 8'hc0);
        chk({7'h0, txd}, 8'h01);
        wr(asx_pkg::ADDR_BAUD, 8'h00);
        wr(asx_pkg::ADDR_EV_EN, 8'h20);
        wr(asx_pkg::ADDR_CTRL, 8'h0c);
        wr(asx_pkg::ADDR_DATA, 8'ha5);
        rchk(asx_pkg::ADDR_STATUS, 8'hff, 8'h00);
        n = 0;
        // preamble must pass before the start bit
        while (txd !== 1'b0 && n < 400)
        begin
            cyc(1);
            n++;
        end
        if (n >= 400)
        begin
            n_mismatch++;
            end_sim();
        end
        chk({7'h0, n > 130}, 8'h01);
        fr = {1'b1, 8'ha5, 1'b0};
        cyc(8);
        for (int i = 0; i < 10; i++)
        begin
            chk({7'h0, txd}, {7'h0, fr[i]});
            cyc(16);
        end
        rchk(asx_pkg::ADDR_STATUS, 8'hff, 8'hc0);
        chk({7'h0, txd}, 8'h01);
        wr(asx_pkg::ADDR_DATA, 8'h5a);
        send(8'h3c);
        rchk(asx_pkg::ADDR_STATUS, 8'h3c, 8'h20);
        chk({7'h0, irq}, 8'h01);
        wr(asx_pkg::ADDR_EV_EN, 8'h00);
        chk({7'h0, irq}, 8'h00);
        wr(asx_pkg::ADDR_EV_EN, 8'h20);
        chk({7'h0, irq}, 8'h01);
        wr(asx_pkg::ADDR_EV_CLR, 8'h20);
        chk({7'h0, irq}, 8'h00);
        rchk(asx_pkg::ADDR_EV_CLR, 8'hff, 8'h00);
        cyc(200);
        rchk(asx_pkg::ADDR_STATUS, 8'h3c, 8'h30);
        rchk(asx_pkg::ADDR_DATA, 8'hff, 8'h3c);
        rchk(asx_pkg::ADDR_STATUS, 8'h3c, 8'h00);
        cyc(300);
        rchk(asx_pkg::ADDR_STATUS, 8'h3c, 8'h00);
        send(8'h11);
        send(8'h22);
        rchk(asx_pkg::ADDR_STATUS, 8'h28, 8'h28);
        rchk(asx_pkg::ADDR_DATA, 8'hff, 8'h11);
        rchk(asx_pkg::ADDR_STATUS, 8'h28, 8'h00);
        // break request after a status read showing complete
        rchk(asx_pkg::ADDR_STATUS, 8'h40, 8'h40);
        wr(asx_pkg::ADDR_CTRL, 8'h0d);
        cyc(20);
        chk({7'h0, txd}, 8'h00);
        rchk(asx_pkg::ADDR_STATUS, 8'h40, 8'h00);
        // one disagreeing sample in a data bit
        noisy <= 1'b1;
        send(8'h40);
        rchk(asx_pkg::ADDR_STATUS, 8'h24, 8'h24);
        rchk(asx_pkg::ADDR_DATA, 8'hff, 8'h40);
        rchk(asx_pkg::ADDR_STATUS, 8'h24, 8'h00);
        wr(asx_pkg::ADDR_CFG, 8'h01);
        cyc(2);
        chk({7'h0, txd}, 8'h00);
        end_sim();
    end
endmodule
